// ==== include/trps_consts.svh ====
// Constants of the three-rail power sequencer
`ifndef TRPS_CONSTS_SVH
`define TRPS_CONSTS_SVH
`define TRPS_CLK_HZ 10000000
`define TRPS_CNT_W 24
`define TRPS_DELAY_MS 30
`define TRPS_DELAY_CYC ((`TRPS_DELAY_MS * `TRPS_CLK_HZ) / 1000)
`define TRPS_REFRESH_US 400
`define TRPS_REFRESH_CYC ((`TRPS_REFRESH_US * `TRPS_CLK_HZ) / 1000000)
`define TRPS_SETTLE_MS 120
`define TRPS_SETTLE_CYC ((`TRPS_SETTLE_MS * `TRPS_CLK_HZ) / 1000)
`define TRPS_ORDER_REVERSE 3'h1
`define TRPS_CTRL_OFS 12'h000
`define TRPS_STATUS_OFS 12'h004
`define TRPS_CONFIG_OFS 12'h008
`define TRPS_CTRL_GATE_BIT 0
`define TRPS_CTRL_RST 32'h00000001
`endif

// ==== include/trps_pkg.sv ====
// Types of the three-rail power sequencer
package trps_pkg;
   typedef enum logic [2:0] {
      ST_OFF,
      ST_UP,
      ST_ON,
      ST_SETTLE,
      ST_DOWN
   } trps_state_e;

   // Flag index (0..2) cleared at each power-down step
   typedef struct packed {
      logic [1:0] third;
      logic [1:0] second;
      logic [1:0] first;
   } trps_order_s;

   typedef struct packed {
      logic [19:0] zero;
      trps_state_e state;
      logic [1:0] step;
      logic enable;
      logic [2:0] pin;
      logic [2:0] released;
   } trps_status_s;
endpackage

// ==== rtl/trps_delay_timer.sv ====
// Delay counter shared by all sequencing steps
`timescale 1ns/100ps
`include "trps_consts.svh"
module trps_delay_timer (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_restart,
   input wire logic [`TRPS_CNT_W-1:0] i_limit,
   output logic [`TRPS_CNT_W-1:0] o_count,
   output logic o_done
);
   logic [`TRPS_CNT_W-1:0] count_q;

   assign o_done = (count_q == i_limit - `TRPS_CNT_W'(1));
   assign o_count = count_q;

   // Holds at limit minus one so done stays up until the next restart
   always_ff @(posedge i_mclk) begin
      if (i_rst || i_restart) begin
         count_q <= '0;
      end else if (!o_done) begin
         count_q <= count_q + `TRPS_CNT_W'(1);
      end
   end
endmodule // trps_delay_timer

// ==== rtl/trps_sequencer.sv ====
// Three-rail power sequencer with APB status and control
// Function
// - after enable, release outputs 1, 2, 3 in turn, each after its delay
// - after enable falls, pull outputs low one at a time
// - option codes 1..6 choose power-down order; power-up always 1-2-3
// - six delays, one timing option of 10, 30, 60 or 120 ms
// - first three delays time power-up, last three time power-down
// - first up and first down delays carry an extra 400 us
// - every delay within plus or minus 15 percent of nominal
// - default build uses 30 ms delays and reverse power-down order
// - delays and power-down order are build-time parameters
// - outputs are open drain: drive low, or release to the pull-up
// - all outputs stay low from reset until enable first rises
// - enable drop before first release resets timer, outputs stay low
// - drop mid power-up finishes power-up, waits 120 ms, then powers down
// - first down timer starts at enable fall, others after previous step
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
`include "trps_consts.svh"
module trps_sequencer #(
   // Standard build: 30 ms on all six timers, reverse order
   parameter logic [`TRPS_CNT_W-1:0] P_UP_DELAY_FIRST =
      `TRPS_CNT_W'(`TRPS_DELAY_CYC),
   parameter logic [`TRPS_CNT_W-1:0] P_UP_DELAY_SECOND =
      `TRPS_CNT_W'(`TRPS_DELAY_CYC),
   parameter logic [`TRPS_CNT_W-1:0] P_UP_DELAY_THIRD =
      `TRPS_CNT_W'(`TRPS_DELAY_CYC),
   parameter logic [`TRPS_CNT_W-1:0] P_DOWN_DELAY_FIRST =
      `TRPS_CNT_W'(`TRPS_DELAY_CYC),
   parameter logic [`TRPS_CNT_W-1:0] P_DOWN_DELAY_SECOND =
      `TRPS_CNT_W'(`TRPS_DELAY_CYC),
   parameter logic [`TRPS_CNT_W-1:0] P_DOWN_DELAY_THIRD =
      `TRPS_CNT_W'(`TRPS_DELAY_CYC),
   parameter logic [`TRPS_CNT_W-1:0] P_REFRESH =
      `TRPS_CNT_W'(`TRPS_REFRESH_CYC),
   parameter logic [`TRPS_CNT_W-1:0] P_SETTLE =
      `TRPS_CNT_W'(`TRPS_SETTLE_CYC),
   parameter logic [2:0] P_DOWN_ORDER = `TRPS_ORDER_REVERSE
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_enable,
   input wire logic [2:0] i_rail_release_out,
   output logic [2:0] o_rail_release_out,
   output logic [2:0] o_rail_release_out_oe,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);
   function automatic trps_pkg::trps_order_s f_order(input logic [2:0] opt);
      trps_pkg::trps_order_s o;
      case (opt)
         3'h1: o = '{first: 2'h2, second: 2'h1, third: 2'h0};
         3'h2: o = '{first: 2'h2, second: 2'h0, third: 2'h1};
         3'h3: o = '{first: 2'h1, second: 2'h2, third: 2'h0};
         3'h4: o = '{first: 2'h1, second: 2'h0, third: 2'h2};
         3'h5: o = '{first: 2'h0, second: 2'h2, third: 2'h1};
         3'h6: o = '{first: 2'h0, second: 2'h1, third: 2'h2};
         default: o = '{first: 2'h2, second: 2'h1, third: 2'h0};
      endcase
      return o;
   endfunction

   localparam trps_pkg::trps_order_s ORDER = f_order(P_DOWN_ORDER);
   localparam logic [31:0] CTRL_RST = `TRPS_CTRL_RST;

   trps_pkg::trps_state_e state_q, state_d;
   logic [1:0] step_q, step_d;
   logic [2:0] released_q, released_d;
   logic abort_q, abort_d;
   logic en_meta_q, en_sync_q, en_prev_q, en_eff, en_fall;
   logic [2:0] pin_meta_q, pin_sync_q;
   logic ctrl_gate_q;
   logic [31:0] prdata_q;
   logic tmr_restart, tmr_done;
   logic [`TRPS_CNT_W-1:0] tmr_limit, tmr_count;
   logic [1:0] dn_flag;
   trps_pkg::trps_status_s status;

   // Pin inputs pass two flops before any logic looks at them
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         en_meta_q <= 1'b0;
         en_sync_q <= 1'b0;
         pin_meta_q <= 3'h0;
         pin_sync_q <= 3'h0;
      end else begin
         en_meta_q <= i_enable;
         en_sync_q <= en_meta_q;
         pin_meta_q <= i_rail_release_out;
         pin_sync_q <= pin_meta_q;
      end
   end

   assign en_eff = en_sync_q & ctrl_gate_q;
   assign en_fall = en_prev_q & ~en_eff;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         en_prev_q <= 1'b0;
      end else begin
         en_prev_q <= en_eff;
      end
   end

   always_comb begin
      case (step_q)
         2'h0: dn_flag = ORDER.first;
         2'h1: dn_flag = ORDER.second;
         default: dn_flag = ORDER.third;
      endcase
   end

   // Step delay; refresh offset only on the first step of each direction
   always_comb begin
      case (state_q)
         trps_pkg::ST_UP: begin
            case (step_q)
               2'h0: tmr_limit = P_UP_DELAY_FIRST + P_REFRESH;
               2'h1: tmr_limit = P_UP_DELAY_SECOND;
               default: tmr_limit = P_UP_DELAY_THIRD;
            endcase
         end
         trps_pkg::ST_DOWN: begin
            case (step_q)
               2'h0: tmr_limit = P_DOWN_DELAY_FIRST + P_REFRESH;
               2'h1: tmr_limit = P_DOWN_DELAY_SECOND;
               default: tmr_limit = P_DOWN_DELAY_THIRD;
            endcase
         end
         trps_pkg::ST_SETTLE: tmr_limit = P_SETTLE;
         default: tmr_limit = P_UP_DELAY_FIRST;
      endcase
   end

   // Exact cycle counts keep every delay well inside the tolerance
   trps_delay_timer u_timer (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_restart(tmr_restart),
      .i_limit(tmr_limit),
      .o_count(tmr_count),
      .o_done(tmr_done)
   );

   always_comb begin
      state_d = state_q;
      step_d = step_q;
      released_d = released_q;
      abort_d = abort_q;
      tmr_restart = 1'b0;
      case (state_q)
         trps_pkg::ST_OFF: begin
            released_d = 3'h0;
            abort_d = 1'b0;
            if (en_eff) begin
               state_d = trps_pkg::ST_UP;
               step_d = 2'h0;
               tmr_restart = 1'b1;
            end
         end
         trps_pkg::ST_UP: begin
            if (step_q == 2'h0 && !en_eff) begin
               state_d = trps_pkg::ST_OFF;
            end else if (tmr_done) begin
               released_d[step_q] = 1'b1;
               // A fall on the release edge must not be lost
               abort_d = abort_q | en_fall;
               tmr_restart = 1'b1;
               if (step_q == 2'h2) begin
                  step_d = 2'h0;
                  state_d = (abort_q || en_fall) ? trps_pkg::ST_SETTLE
                                                 : trps_pkg::ST_ON;
               end else begin
                  step_d = step_q + 2'h1;
               end
            end else if (en_fall) begin
               // Falling edge restarts the running step, power-up goes on
               abort_d = 1'b1;
               tmr_restart = 1'b1;
            end
         end
         trps_pkg::ST_ON: begin
            if (!en_eff) begin
               state_d = trps_pkg::ST_DOWN;
               step_d = 2'h0;
               tmr_restart = 1'b1;
            end
         end
         trps_pkg::ST_SETTLE: begin
            if (tmr_done) begin
               state_d = trps_pkg::ST_DOWN;
               step_d = 2'h0;
               tmr_restart = 1'b1;
            end
         end
         trps_pkg::ST_DOWN: begin
            if (tmr_done) begin
               released_d[dn_flag] = 1'b0;
               tmr_restart = 1'b1;
               if (step_q == 2'h2) begin
                  state_d = trps_pkg::ST_OFF;
                  step_d = 2'h0;
               end else begin
                  step_d = step_q + 2'h1;
               end
            end
         end
         default: begin
            state_d = trps_pkg::ST_OFF;
            step_d = 2'h0;
            released_d = 3'h0;
            abort_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_q <= trps_pkg::ST_OFF;
         step_q <= 2'h0;
         released_q <= 3'h0;
         abort_q <= 1'b0;
      end else begin
         state_q <= state_d;
         step_q <= step_d;
         released_q <= released_d;
         abort_q <= abort_d;
      end
   end

   // Open drain: pull low unless released
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_pin
         assign o_rail_release_out[g] = 1'b0;
         assign o_rail_release_out_oe[g] = ~released_q[g];
      end
   endgenerate

   // APB slave, zero wait states; read data set up in the setup phase
   logic apb_setup, apb_access, addr_ok;
   assign apb_setup = i_psel & ~i_penable;
   assign apb_access = i_psel & i_penable;
   assign addr_ok = (i_paddr == `TRPS_CTRL_OFS) ||
                    (i_paddr == `TRPS_STATUS_OFS) ||
                    (i_paddr == `TRPS_CONFIG_OFS);
   assign o_pready = 1'b1;
   assign o_pslverr = apb_access & ~addr_ok;
   assign o_prdata = prdata_q;

   always_comb begin
      status = '0;
      status.state = state_q;
      status.step = step_q;
      status.enable = en_sync_q;
      status.pin = pin_sync_q;
      status.released = released_q;
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ctrl_gate_q <= CTRL_RST[`TRPS_CTRL_GATE_BIT];
      end else if (apb_access && i_pwrite &&
                   i_paddr == `TRPS_CTRL_OFS) begin
         ctrl_gate_q <= i_pwdata[`TRPS_CTRL_GATE_BIT];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         prdata_q <= 32'h00000000;
      end else if (apb_setup && !i_pwrite) begin
         case (i_paddr)
            `TRPS_CTRL_OFS: prdata_q <= {31'h0, ctrl_gate_q};
            `TRPS_STATUS_OFS: prdata_q <= status;
            `TRPS_CONFIG_OFS: prdata_q <= {29'h0, P_DOWN_ORDER};
            default: prdata_q <= 32'h00000000;
         endcase
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   property p_off_low;
      state_q == trps_pkg::ST_OFF |-> released_q == 3'h0;
   endproperty
   a_off_low: assert property (p_off_low)
      else $error("outputs released while off");

   property p_early_drop;
      state_q == trps_pkg::ST_UP && step_q == 2'h0 && !en_eff |=>
         state_q == trps_pkg::ST_OFF && released_q == 3'h0;
   endproperty
   a_early_drop: assert property (p_early_drop)
      else $error("early enable drop did not abort");

   property p_up_in_order;
      $rose(released_q[1]) || $rose(released_q[2]) |->
         $past(released_q) == ($rose(released_q[2]) ? 3'h3 : 3'h1);
   endproperty
   a_up_in_order: assert property (p_up_in_order)
      else $error("release out of order");

   property p_up_after_delay;
      $rose(released_q[0]) |-> $past(tmr_done) &&
         $past(tmr_count) == P_UP_DELAY_FIRST + P_REFRESH - 24'h000001;
   endproperty
   a_up_after_delay: assert property (p_up_after_delay)
      else $error("first release not after first delay");

   property p_down_order;
      state_q == trps_pkg::ST_DOWN && tmr_done |=>
         released_q == ($past(released_q) & ~(3'h1 << $past(dn_flag)));
   endproperty
   a_down_order: assert property (p_down_order)
      else $error("wrong flag pulled low");

   property p_one_fall;
      state_q == trps_pkg::ST_DOWN |=>
         $countones($past(released_q) & ~released_q) <= 1;
   endproperty
   a_one_fall: assert property (p_one_fall)
      else $error("more than one flag fell");

   property p_down_start;
      state_q == trps_pkg::ST_ON && !en_eff |=>
         state_q == trps_pkg::ST_DOWN && step_q == 2'h0 &&
         tmr_count == '0;
   endproperty
   a_down_start: assert property (p_down_start)
      else $error("power-down timer not started at enable fall");

   property p_settle;
      state_q == trps_pkg::ST_UP && step_q == 2'h2 && tmr_done &&
         (abort_q || en_fall) |=> state_q == trps_pkg::ST_SETTLE;
   endproperty
   a_settle: assert property (p_settle)
      else $error("aborted power-up skipped the settle wait");

   property p_down_finishes;
      state_q == trps_pkg::ST_DOWN |=>
         state_q == trps_pkg::ST_DOWN || state_q == trps_pkg::ST_OFF;
   endproperty
   a_down_finishes: assert property (p_down_finishes)
      else $error("power-down interrupted");

   property p_open_drain;
      o_rail_release_out == 3'h0 && o_rail_release_out_oe == ~released_q;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("open-drain pin driven high");

   c_full_up: cover property (state_q == trps_pkg::ST_ON);
   c_settle: cover property (state_q == trps_pkg::ST_SETTLE);
   c_down_done: cover property (state_q == trps_pkg::ST_DOWN ##1
      state_q == trps_pkg::ST_OFF);
   c_reenable: cover property (state_q == trps_pkg::ST_DOWN && en_eff);
endmodule // trps_sequencer

// ==== verif/trps_rail_model.sv ====
// Far side: regulator enable lines with pull-ups on the open-drain outputs
`timescale 1ns/100ps
module trps_rail_model (
   input wire logic [2:0] i_pull_low,
   input wire logic [2:0] i_drive,
   output logic [2:0] o_level
);
   // A released line floats up to the pull-up, never keeps the last value
   for (genvar b = 0; b < 3; b++) begin : g_line
      assign o_level[b] = i_pull_low[b] ? i_drive[b] : 1'b1;
   end
endmodule // trps_rail_model

// ==== verif/trps_sequencer_tb.sv ====
// Self-checking bench for the three-rail power sequencer
`timescale 1ns/100ps
`include "trps_consts.svh"
module trps_sequencer_tb;
   // Distinct delays so a swapped or shared timer shows up
   localparam int UP1 = 20;
   localparam int UP2 = 24;
   localparam int UP3 = 28;
   localparam int DN1 = 16;
   localparam int DN2 = 12;
   localparam int DN3 = 8;
   localparam int RF = 2;
   localparam int SET = 40;
   // Power-down bit order for option codes 1..6
   localparam int ORD [6][3] = '{'{2, 1, 0}, '{2, 0, 1}, '{1, 2, 0},
      '{1, 0, 2}, '{0, 2, 1}, '{0, 1, 2}};
   logic clk, rst, en, en_q, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [2:0] oe [6];
   logic [2:0] oe_q [6];
   logic [2:0] drv [6];
   logic [2:0] pin [6];
   logic [31:0] prd [6];
   logic rdy [6];
   logic serr [6];
   int cyc = 0;
   int errors = 0;
   int check_count = 0;
   int en_up_t, en_dn_t;
   int rel_t [6][3];
   int dn_t [6][3];

   // Order is fixed at build time, so every code gets its own instance
   for (genvar k = 0; k < 6; k++) begin : g_opt
      trps_sequencer #(
         .P_UP_DELAY_FIRST(`TRPS_CNT_W'(UP1)),
         .P_UP_DELAY_SECOND(`TRPS_CNT_W'(UP2)),
         .P_UP_DELAY_THIRD(`TRPS_CNT_W'(UP3)),
         .P_DOWN_DELAY_FIRST(`TRPS_CNT_W'(DN1)),
         .P_DOWN_DELAY_SECOND(`TRPS_CNT_W'(DN2)),
         .P_DOWN_DELAY_THIRD(`TRPS_CNT_W'(DN3)),
         .P_REFRESH(`TRPS_CNT_W'(RF)),
         .P_SETTLE(`TRPS_CNT_W'(SET)),
         .P_DOWN_ORDER(3'(k + 1))
      ) uut (
         .i_mclk(clk),
         .i_rst(rst),
         .i_enable(en),
         .i_rail_release_out(pin[k]),
         .o_rail_release_out(drv[k]),
         .o_rail_release_out_oe(oe[k]),
         .i_psel(psel),
         .i_penable(penable),
         .i_pwrite(pwrite),
         .i_paddr(paddr),
         .i_pwdata(pwdata),
         .o_prdata(prd[k]),
         .o_pready(rdy[k]),
         .o_pslverr(serr[k])
      );
      trps_rail_model model (
         .i_pull_low(oe[k]),
         .i_drive(drv[k]),
         .o_level(pin[k])
      );
   end

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Edge times seen at the pins, in clock cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      en_q <= en;
      if (en === 1'b1 && en_q === 1'b0) en_up_t <= cyc;
      if (en === 1'b0 && en_q === 1'b1) en_dn_t <= cyc;
      for (int k = 0; k < 6; k++) begin
         for (int b = 0; b < 3; b++) begin
            if (oe_q[k][b] === 1'b1 && oe[k][b] === 1'b0) rel_t[k][b] <= cyc;
            if (oe_q[k][b] === 1'b0 && oe[k][b] === 1'b1) dn_t[k][b] <= cyc;
         end
      end
      oe_q <= oe;
   end

   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, hi, g);
      check_count++;
      if (g < lo || g > hi) begin
         errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rdy[0] !== 1'b1 && n < 50);
      rd = prd[0];
      er = serr[0];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic set_en(input logic v);
      @(posedge clk);
      en <= v;
   endtask

   // Bounded wait for masked outputs, then one edge for the edge log
   task automatic wait_oe(input int k, input logic [2:0] m, v);
      int n;
      n = 0;
      while ((oe[k] & m) !== v && n < 500) begin
         @(posedge clk);
         n++;
      end
      chk("oe wait", 32'(v), 32'(oe[k] & m));
      @(posedge clk);
   endtask

   task automatic t_reset;
      logic [31:0] rd;
      logic er;
      chk("oe after reset", 32'h7, 32'(oe[0]));
      chk("pin drive", 32'h0, 32'(drv[0]));
      chk("pin level", 32'h0, 32'(pin[0]));
      chk("pready", 32'h1, 32'(rdy[0]));
      apb(1'b0, `TRPS_CONFIG_OFS, 32'h0, rd, er);
      chk("mapped error", 32'h0, 32'(er));
      for (int k = 0; k < 6; k++) chk("order", 32'(k + 1), prd[k]);
      apb(1'b0, 12'h00C, 32'h0, rd, er);
      chk("unmapped error", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, rd);
   endtask

   task automatic t_glitch_and_gate;
      logic [31:0] rd;
      logic er;
      set_en(1'b1);
      repeat (10) @(posedge clk);
      set_en(1'b0);
      repeat (40) @(posedge clk);
      for (int k = 0; k < 6; k++) chk("glitch", 32'h7, 32'(oe[k]));
      apb(1'b1, `TRPS_CTRL_OFS, 32'h0, rd, er);
      set_en(1'b1);
      repeat (60) @(posedge clk);
      chk("gated", 32'h7, 32'(oe[0]));
      set_en(1'b0);
      apb(1'b1, `TRPS_CTRL_OFS, `TRPS_CTRL_RST, rd, er);
      apb(1'b0, `TRPS_CTRL_OFS, 32'h0, rd, er);
      chk("gate back", `TRPS_CTRL_RST, rd);
   endtask

   task automatic t_power_up;
      logic [31:0] rd;
      logic er;
      set_en(1'b1);
      wait_oe(0, 3'h7, 3'h0);
      for (int k = 0; k < 6; k++) begin
         chk_rng("up1", UP1 + RF + 1, UP1 + RF + 5, rel_t[k][0] - en_up_t);
         chk("up2", 32'(UP2), 32'(rel_t[k][1] - rel_t[k][0]));
         chk("up3", 32'(UP3), 32'(rel_t[k][2] - rel_t[k][1]));
      end
      // State on, step 0, enable and pins high, all released
      apb(1'b0, `TRPS_STATUS_OFS, 32'h0, rd, er);
      chk("status", 32'h0000047F, rd);
   endtask

   task automatic t_power_down;
      set_en(1'b0);
      for (int k = 0; k < 6; k++) wait_oe(k, 3'h7, 3'h7);
      for (int k = 0; k < 6; k++) begin
         chk_rng("dn1", DN1 + RF + 1, DN1 + RF + 5,
            dn_t[k][ORD[k][0]] - en_dn_t);
         chk("dn2", 32'(DN2),
            32'(dn_t[k][ORD[k][1]] - dn_t[k][ORD[k][0]]));
         chk("dn3", 32'(DN3),
            32'(dn_t[k][ORD[k][2]] - dn_t[k][ORD[k][1]]));
      end
   endtask

   task automatic t_mid_drop;
      set_en(1'b1);
      wait_oe(0, 3'h1, 3'h0);
      set_en(1'b0);
      wait_oe(0, 3'h7, 3'h7);
      chk_rng("restart", UP2 + 1, UP2 + 5, rel_t[0][1] - en_dn_t);
      chk("finish up", 32'(UP3), 32'(rel_t[0][2] - rel_t[0][1]));
      chk_rng("settle", SET, SET + DN1 + RF + 4,
         dn_t[0][2] - rel_t[0][2]);
   endtask

   task automatic t_reenter;
      set_en(1'b1);
      wait_oe(0, 3'h7, 3'h0);
      set_en(1'b0);
      wait_oe(0, 3'h4, 3'h4);
      set_en(1'b1);
      wait_oe(0, 3'h7, 3'h7);
      chk("dn keeps pace", 32'(DN2), 32'(dn_t[0][1] - dn_t[0][2]));
      wait_oe(0, 3'h1, 3'h0);
      chk_rng("new up", UP1 + RF, UP1 + RF + 5,
         rel_t[0][0] - dn_t[0][0]);
      set_en(1'b0);
      wait_oe(0, 3'h7, 3'h7);
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Whole run is under a thousand cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("[FAIL] watchdog expected done seen hang");
      final_report();
   end

   initial begin
      rst = 1'b1;
      en = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_reset();
      t_glitch_and_gate();
      t_power_up();
      t_power_down();
      t_mid_drop();
      t_reenter();
      final_report();
   end
endmodule // trps_sequencer_tb
